// ==== verilog/tsts_pkg.sv ====
// Package for the timer slave-trigger and master link block.
// Assumes a single peripheral clock; registers sit on an Avalon-MM slave.
package tsts_pkg;
	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [3:0] TSTS_OFS_CTRL   = 4'h0;
	localparam logic [3:0] TSTS_OFS_SLAVE  = 4'h4;
	localparam logic [3:0] TSTS_OFS_FLAG   = 4'h8;
	localparam logic [3:0] TSTS_OFS_CNT    = 4'hC;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int TSTS_CTRL_CEN     = 0;
	localparam int TSTS_CTRL_UG      = 1;
	localparam int TSTS_CTRL_MMS_LO  = 4;
	localparam int TSTS_CTRL_PSC_LO  = 8;
	localparam int TSTS_CTRL_ARR_LO  = 16;
	localparam int TSTS_SLV_SMS_LO   = 0;
	localparam int TSTS_SLV_TS_LO    = 4;
	localparam int TSTS_SLV_MSM      = 7;
	localparam int TSTS_SLV_ETF_LO   = 8;
	localparam int TSTS_SLV_ETPS_LO  = 12;
	localparam int TSTS_SLV_ETP      = 14;
	localparam int TSTS_SLV_ECE      = 15;
	localparam int TSTS_SLV_CCR_LO   = 16;
	localparam int TSTS_FLAG_TIF     = 0;
	localparam int TSTS_FLAG_UIF     = 1;
	// ****************************************************************
	// Encodings
	// ****************************************************************
	localparam logic [2:0] TSTS_SMS_GATED = 3'h5;
	localparam logic [2:0] TSTS_SMS_TRIG  = 3'h6;
	localparam logic [2:0] TSTS_SMS_EXT1  = 3'h7;
	localparam logic [2:0] TSTS_SMS_RESET = 3'h4;
	localparam logic [2:0] TSTS_TS_ITR_A  = 3'h0;
	localparam logic [2:0] TSTS_TS_ITR_B  = 3'h4;
	localparam logic [2:0] TSTS_TS_CH1    = 3'h5;
	localparam logic [2:0] TSTS_TS_CH2    = 3'h6;
	localparam logic [2:0] TSTS_TS_ETR    = 3'h7;
	localparam logic [2:0] TSTS_MMS_EN    = 3'h1;
	localparam logic [2:0] TSTS_MMS_UPD   = 3'h2;
	localparam logic [2:0] TSTS_MMS_OC1   = 3'h4;
	localparam logic [31:0] TSTS_RST_WORD = 32'h0000_0000;
	localparam logic [31:0] TSTS_RST_ARR  = 32'h0000_FFFF;

	typedef struct packed {
		logic       cen;
		logic [2:0] mms;
		logic [7:0] psc;
		logic [15:0] arr;
	} tsts_ctrl_t;

	typedef struct packed {
		logic [2:0] sms;
		logic [2:0] ts;
		logic       msm;
		logic [3:0] etf;
		logic [1:0] etps;
		logic       etp;
		logic       ece;
		logic [15:0] ccr;
	} tsts_slave_t;
endpackage

// ==== verilog/tsts_timer.sv ====
// One general-purpose timer with slave trigger control and master output.
// Assumes channel inputs and the external trigger pin are asynchronous pins,
// and that the link input comes from the partner timer on the same clock.
// What this block does
// - Slave mode 110 starts the counter on an active trigger event.
// - Trigger edge starts counting on internal clock and sets trigger flag.
// - External trigger inputs are resynchronized, so start lags the edge.
// - Trigger select 101 routes channel 1, 110 routes channel 2.
// - Trigger select 000 (and 100) route the partner's trigger output.
// - External clock mode 2 combines with reset, gated or trigger modes.
// - External path has filter, prescaler, polarity; enable bit selects mode 2.
// - Mode 2 plus trigger: edge enables counter, then pin edges count.
// - Master can reset, start, stop or clock the partner through a link.
// - Master mode 010 pulses trigger output on every update event.
// - Master mode 1xx drives a compare reference; 100 is channel 1.
// - Master mode 001 outputs the counter enable signal.
// - Slave mode 111 clocks the counter on trigger rising edges.
// - Gated mode counts prescaled internal clock while trigger is high.
// - Gating touches only the counter enable, not the count clock.
// - Counter and prescaler resume from current values when started.
// - Writing the update generate bit resets counter and prescaler.
// - Software writes to the counter register load the counter.
// - Trigger mode sets enable bit; it stays until software clears it.
// - Slave gated by master enable output (mode 001) stops when master enable clears; a compare gate holds its level.
// - Master/slave bit delays master enable to its prescaler input.
// - Master started by channel with master/slave bit set counts one clock ahead of a slave in trigger mode.
// - Event flags clear when software writes one to their bit.
// - Internal trigger input connects to the partner's trigger output.
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module tsts_timer (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        CH1_IN,
	input  wire logic        CH2_IN,
	input  wire logic        ETR_PIN,
	input  wire logic        LINK_IN,
	output logic             TRIGGER_OUTPUT,
	output logic             COMPARE1_OUT,
	output logic [15:0]      COUNT_VALUE
);
	// ****************************************************************
	// Input resynchronizers
	// ****************************************************************
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;
	logic [2:0] pins;
	assign pins = {ETR_PIN, CH2_IN, CH1_IN};

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ****************************************************************
	// Registers and bus
	// ****************************************************************
	tsts_pkg::tsts_ctrl_t  ctrl_q;
	tsts_pkg::tsts_slave_t slv_q;
	logic [15:0] cnt_q;
	logic [7:0]  psc_cnt_q;
	logic        tif_q;
	logic        uif_q;
	logic        rd_ack_q;
	logic [31:0] rdata_q;

	// Reads take one wait cycle so read data comes from a flop; writes are immediate.
	assign AVS_WAITREQUEST = AVS_READ & ~rd_ack_q;

	wire wr_ctrl  = AVS_WRITE && AVS_ADDRESS == tsts_pkg::TSTS_OFS_CTRL;
	wire wr_slave = AVS_WRITE && AVS_ADDRESS == tsts_pkg::TSTS_OFS_SLAVE;
	wire wr_flag  = AVS_WRITE && AVS_ADDRESS == tsts_pkg::TSTS_OFS_FLAG;
	wire wr_cnt   = AVS_WRITE && AVS_ADDRESS == tsts_pkg::TSTS_OFS_CNT;
	wire ug_write = wr_ctrl && AVS_BYTEENABLE[0] && AVS_WRITEDATA[tsts_pkg::TSTS_CTRL_UG];

	wire [31:0] ctrl_word = {ctrl_q.arr, ctrl_q.psc, 1'b0, ctrl_q.mms, 3'h0, ctrl_q.cen};
	wire [31:0] slv_word  = {slv_q.ccr, slv_q.ece, slv_q.etp, slv_q.etps, slv_q.etf,
	                         slv_q.msm, slv_q.ts, 1'b0, slv_q.sms};
	wire [31:0] rd_mux =
		(AVS_ADDRESS == tsts_pkg::TSTS_OFS_CTRL)  ? ctrl_word :
		(AVS_ADDRESS == tsts_pkg::TSTS_OFS_SLAVE) ? slv_word :
		(AVS_ADDRESS == tsts_pkg::TSTS_OFS_FLAG)  ? {30'h0, uif_q, tif_q} :
		(AVS_ADDRESS == tsts_pkg::TSTS_OFS_CNT)   ? {16'h0, cnt_q} : 32'h0000_0000;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	wire [31:0] ctrl_wr = merge(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
	wire [31:0] slv_wr  = merge(slv_word, AVS_WRITEDATA, AVS_BYTEENABLE);
	wire [31:0] cnt_wr  = merge({16'h0, cnt_q}, AVS_WRITEDATA, AVS_BYTEENABLE);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rd_ack_q <= 1'b0;
			rdata_q  <= tsts_pkg::TSTS_RST_WORD;
		end else begin
			rd_ack_q <= AVS_READ & ~rd_ack_q;
			rdata_q  <= rd_mux;
		end
	end
	assign AVS_READDATA = rdata_q;

	// ****************************************************************
	// Trigger selection and external trigger conditioning
	// ****************************************************************
	wire [2:0] ts = slv_q.ts;
	wire       ch1_f = sync2_q[0];
	wire       ch2_f = sync2_q[1];
	wire       etr_lv = sync2_q[2] ^ slv_q.etp;
	wire       etr_lv_d = sync3_q[2] ^ slv_q.etp;
	wire       etr_rise = etr_lv & ~etr_lv_d;

	// Filter: level must stay stable for etf cycles; zero passes straight through.
	logic [3:0] flt_cnt_q;
	logic       etr_flt_q;
	logic [2:0] etps_cnt_q;
	logic       etr_edge_q;
	wire        etr_stable = (flt_cnt_q >= slv_q.etf);
	wire        etr_f_rise = (slv_q.etf == 4'h0) ? etr_rise : (etr_stable & etr_lv & ~etr_flt_q);
	// Three bits so that the divide-by-eight setting really waits eight edges.
	wire [2:0]  etps_max = (3'h1 << slv_q.etps) - 3'h1;
	wire        etps_hit = (slv_q.etps == 2'h0) || (etps_cnt_q == etps_max);

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			flt_cnt_q  <= 4'h0;
			etr_flt_q  <= 1'b0;
			etps_cnt_q <= 3'h0;
			etr_edge_q <= 1'b0;
		end else begin
			flt_cnt_q  <= (etr_lv != etr_lv_d) ? 4'h0 :
			              (flt_cnt_q == 4'hF) ? flt_cnt_q : flt_cnt_q + 4'h1;
			etr_flt_q  <= (slv_q.etf == 4'h0 || etr_stable) ? etr_lv : etr_flt_q;
			etps_cnt_q <= etr_f_rise ? (etps_hit ? 3'h0 : etps_cnt_q + 3'h1) : etps_cnt_q;
			etr_edge_q <= etr_f_rise & etps_hit;
		end
	end
	wire etr_cond = etr_edge_q;   // conditioned external trigger pulse

	// Software is expected not to pick the pin as trigger; it still works as a level.
	wire trig_lv =
		(ts == tsts_pkg::TSTS_TS_CH1) ? ch1_f :
		(ts == tsts_pkg::TSTS_TS_CH2) ? ch2_f :
		(ts == tsts_pkg::TSTS_TS_ETR) ? etr_flt_q :
		(ts == tsts_pkg::TSTS_TS_ITR_A || ts == tsts_pkg::TSTS_TS_ITR_B) ? LINK_IN : 1'b0;

	logic trig_d_q;
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			trig_d_q <= 1'b0;
		end else begin
			trig_d_q <= trig_lv;
		end
	end
	wire trig_rise = trig_lv & ~trig_d_q;
	wire trig_edge = trig_lv ^ trig_d_q;

	// ****************************************************************
	// Slave mode control
	// ****************************************************************
	wire sms_trig  = slv_q.sms == tsts_pkg::TSTS_SMS_TRIG;
	wire sms_gated = slv_q.sms == tsts_pkg::TSTS_SMS_GATED;
	wire sms_ext1  = slv_q.sms == tsts_pkg::TSTS_SMS_EXT1;
	wire sms_reset = slv_q.sms == tsts_pkg::TSTS_SMS_RESET;
	wire trig_start = sms_trig & trig_rise;
	// Mode 2 is ignored while mode 1 is selected.
	wire ext2_on = slv_q.ece & ~sms_ext1;

	// Enable bit: trigger sets it, software write may clear; set wins.
	wire cen_sw = wr_ctrl & AVS_BYTEENABLE[0];
	wire cen_d  = trig_start ? 1'b1 :
	              cen_sw ? AVS_WRITEDATA[tsts_pkg::TSTS_CTRL_CEN] : ctrl_q.cen;
	wire count_enable_signal = ctrl_q.cen & (~sms_gated | trig_lv);

	// Optional one-cycle delay of enable toward the prescaler for alignment.
	logic count_enable_signal_dly_q;
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			count_enable_signal_dly_q <= 1'b0;
		end else begin
			count_enable_signal_dly_q <= count_enable_signal;
		end
	end
	wire psc_en = slv_q.msm ? count_enable_signal_dly_q : count_enable_signal;

	// ****************************************************************
	// Prescaler and counter
	// ****************************************************************
	wire clk_tick = sms_ext1 ? trig_rise :
	                ext2_on  ? etr_cond : 1'b1;
	wire psc_tick = psc_en & clk_tick;
	wire psc_wrap = psc_tick && (psc_cnt_q == ctrl_q.psc);
	wire ovf      = psc_wrap && (cnt_q == ctrl_q.arr);
	wire reset_ev = ug_write | (sms_reset & trig_rise);
	wire update_ev = ovf | reset_ev;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			cnt_q     <= 16'h0000;
			psc_cnt_q <= 8'h00;
		end else if (reset_ev) begin
			cnt_q     <= 16'h0000;
			psc_cnt_q <= 8'h00;
		end else if (wr_cnt) begin
			cnt_q     <= cnt_wr[15:0];
		end else if (psc_tick) begin
			// Start by gate or trigger keeps the present values.
			psc_cnt_q <= psc_wrap ? 8'h00 : psc_cnt_q + 8'h01;
			cnt_q     <= !psc_wrap ? cnt_q : (ovf ? 16'h0000 : cnt_q + 16'h0001);
		end
	end

	// ****************************************************************
	// Registers and flags
	// ****************************************************************
	wire tif_set = trig_start | (sms_gated & trig_edge) | (sms_reset & trig_rise);
	wire [31:0] flag_clr = (wr_flag & AVS_BYTEENABLE[0]) ? AVS_WRITEDATA : 32'h0;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ctrl_q <= '{cen: 1'b0, mms: 3'h0, psc: 8'h00, arr: tsts_pkg::TSTS_RST_ARR[15:0]};
			slv_q  <= tsts_pkg::TSTS_RST_WORD[30:0];
			tif_q  <= 1'b0;
			uif_q  <= 1'b0;
		end else begin
			ctrl_q.cen <= cen_d;
			if (wr_ctrl) begin
				ctrl_q.mms <= ctrl_wr[tsts_pkg::TSTS_CTRL_MMS_LO +: 3];
				ctrl_q.psc <= ctrl_wr[tsts_pkg::TSTS_CTRL_PSC_LO +: 8];
				ctrl_q.arr <= ctrl_wr[tsts_pkg::TSTS_CTRL_ARR_LO +: 16];
			end
			if (wr_slave) begin
				slv_q <= {slv_wr[tsts_pkg::TSTS_SLV_SMS_LO +: 3],
				          slv_wr[tsts_pkg::TSTS_SLV_TS_LO +: 3],
				          slv_wr[tsts_pkg::TSTS_SLV_MSM],
				          slv_wr[tsts_pkg::TSTS_SLV_ETF_LO +: 4],
				          slv_wr[tsts_pkg::TSTS_SLV_ETPS_LO +: 2],
				          slv_wr[tsts_pkg::TSTS_SLV_ETP],
				          slv_wr[tsts_pkg::TSTS_SLV_ECE],
				          slv_wr[tsts_pkg::TSTS_SLV_CCR_LO +: 16]};
			end
			tif_q <= tif_set | (tif_q & ~flag_clr[tsts_pkg::TSTS_FLAG_TIF]);
			uif_q <= update_ev | (uif_q & ~flag_clr[tsts_pkg::TSTS_FLAG_UIF]);
		end
	end

	// ****************************************************************
	// Master output
	// ****************************************************************
	logic trigger_output_q;
	logic oc1_q;
	wire  oc1_ref = cnt_q < slv_q.ccr;
	wire [2:0] mms = ctrl_q.mms;
	wire trigger_output_d = (mms == tsts_pkg::TSTS_MMS_EN)  ? count_enable_signal :
	              (mms == tsts_pkg::TSTS_MMS_UPD) ? update_ev :
	              mms[2] ? oc1_ref : reset_ev;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			trigger_output_q <= 1'b0;
			oc1_q  <= 1'b0;
		end else begin
			trigger_output_q <= trigger_output_d;
			oc1_q  <= oc1_ref;
		end
	end
	assign TRIGGER_OUTPUT = trigger_output_q;
	assign COMPARE1_OUT   = oc1_q;
	assign COUNT_VALUE    = cnt_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_trig_sets_cen;
		@(posedge CLK) disable iff (!RSTN) trig_start |=> ctrl_q.cen && tif_q;
	endproperty
	a_trig_sets_cen: assert property (p_trig_sets_cen) else $error("trigger did not start");

	property p_sync_lat;
		@(posedge CLK) disable iff (!RSTN)
			(sms_trig && ts == tsts_pkg::TSTS_TS_CH1 && $rose(CH1_IN) && !ch1_f)
			##1 CH1_IN |=> trig_rise;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("sync latency wrong");

	property p_ch2_route;
		@(posedge CLK) disable iff (!RSTN) ts == tsts_pkg::TSTS_TS_CH2 |-> trig_lv == sync2_q[1];
	endproperty
	a_ch2_route: assert property (p_ch2_route) else $error("channel 2 routing wrong");

	property p_link_route;
		@(posedge CLK) disable iff (!RSTN) ts == tsts_pkg::TSTS_TS_ITR_A |-> trig_lv == LINK_IN;
	endproperty
	a_link_route: assert property (p_link_route) else $error("link routing wrong");

	property p_upd_out;
		@(posedge CLK) disable iff (!RSTN)
			mms == tsts_pkg::TSTS_MMS_UPD && update_ev && !wr_ctrl |=> TRIGGER_OUTPUT;
	endproperty
	a_upd_out: assert property (p_upd_out) else $error("update not on output");

	property p_gate_hold;
		@(posedge CLK) disable iff (!RSTN)
			sms_gated && !trig_lv && !reset_ev && !wr_cnt && !(slv_q.msm && count_enable_signal_dly_q)
			|=> $stable(cnt_q);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gated counter moved");

	property p_ug_reset;
		@(posedge CLK) disable iff (!RSTN) ug_write |=> cnt_q == 16'h0000 && psc_cnt_q == 8'h00;
	endproperty
	a_ug_reset: assert property (p_ug_reset) else $error("update generate failed");

	property p_cnt_load;
		@(posedge CLK) disable iff (!RSTN)
			wr_cnt && !reset_ev |=> cnt_q == $past(cnt_wr[15:0]);
	endproperty
	a_cnt_load: assert property (p_cnt_load) else $error("counter load failed");

	property p_flag_set_wins;
		@(posedge CLK) disable iff (!RSTN) tif_set |=> tif_q;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("trigger flag lost");

	property p_msm_delay;
		@(posedge CLK) disable iff (!RSTN)
			slv_q.msm && $rose(count_enable_signal) |-> !psc_en ##1 (psc_en || !count_enable_signal);
	endproperty
	a_msm_delay: assert property (p_msm_delay) else $error("align delay wrong");

	c_trig_start: cover property (@(posedge CLK) disable iff (!RSTN) trig_start);
	c_ext2_count: cover property (@(posedge CLK) disable iff (!RSTN) ext2_on && psc_tick);
	c_gated_run:  cover property (@(posedge CLK) disable iff (!RSTN) sms_gated && psc_tick);
	c_ext1_tick:  cover property (@(posedge CLK) disable iff (!RSTN) sms_ext1 && psc_tick);
endmodule

// ==== test/tsts_link_model.sv ====
// Behavioural stand-in for the partner timer's trigger output.
// Assumes the same clock as the timer under test and a synchronous low reset.
`timescale 1ns/100ps
module tsts_link_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic gate_req,
	input  wire logic pulse_req,
	output logic      link
);
	// ****************************************************************
	// Trigger output
	// ****************************************************************
	// A level request stands for an enable or compare reference output, a
	// one-cycle request for an update pulse; both leave a register, as the
	// real master's output does, so the far side sees no combinational path.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			link <= 1'b0;
		end else begin
			link <= gate_req | pulse_req;
		end
	end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for one timer with its partner link modelled.
// Assumes the register layout and encodings of the timer package.
`timescale 1ns/100ps
module testbench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q;
	logic        ch1 = 1'b0;
	logic        ch2 = 1'b0;
	logic        ext_trigger_pin = 1'b0;
	logic        gate = 1'b0;
	logic        pls = 1'b0;
	logic [15:0] c1;
	logic [15:0] c2;
	logic [15:0] ccr;
	// The external pin is never chosen as trigger source.
	logic [2:0]  tsel [4] = '{3'h5, 3'h6, 3'h0, 3'h4};
	wire         link;
	wire         trigger_output;
	wire         cmp1;
	wire         wreq;
	wire  [31:0] avs_rd;
	wire  [15:0] cnt;
	int          mismatches = 0;
	int          num_checks = 0;
	int          k;

	always #20 clk = ~clk;

	tsts_timer u_dut (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(avs_rd),
		.AVS_WAITREQUEST(wreq), .CH1_IN(ch1), .CH2_IN(ch2), .ETR_PIN(ext_trigger_pin), .LINK_IN(link),
		.TRIGGER_OUTPUT(trigger_output), .COMPARE1_OUT(cmp1), .COUNT_VALUE(cnt));
	tsts_link_model u_link (.clk(clk), .rstn(rstn), .gate_req(gate), .pulse_req(pls),
		.link(link));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] ctrl_w(logic cen, logic ug, logic [2:0] mms, logic [15:0] arr);
		return {arr, 8'h00, 1'b0, mms, 2'b00, ug, cen};
	endfunction
	function automatic logic [31:0] slv_w(logic [2:0] sms, logic [2:0] ts, logic ece,
		logic [15:0] cc);
		return {cc, ece, 1'b0, 2'b00, 4'h0, 1'b0, ts, 1'b0, sms};
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// The request is held until the edge where waitrequest is low.
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20) mismatches++;
		q = avs_rd;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask
	task pulses(input int n, input logic on_etr);
		repeat (n) begin
			@(posedge clk);
			if (on_etr) ext_trigger_pin <= 1'b1;
			else pls <= 1'b1;
			@(posedge clk);
			ext_trigger_pin <= 1'b0;
			pls <= 1'b0;
			wt(3);
		end
	endtask
	task restart(input logic [31:0] slave);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b0, 1'b1, 3'h0, 16'hFFFF));
		bus(1'b1, tsts_pkg::TSTS_OFS_SLAVE, slave);
	endtask
	task final_report;
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		wt(40000);
		mismatches++;
		final_report;
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		k = $urandom(32'hddb1698b);
		wt(6);
		rstn <= 1'b1;
		rd_chk(tsts_pkg::TSTS_OFS_CTRL, 32'hFFFF_0000);
		rd_chk(tsts_pkg::TSTS_OFS_SLAVE, 32'h0);
		rd_chk(tsts_pkg::TSTS_OFS_FLAG, 32'h0);
		rd_chk(4'h2, 32'h0);
		// Trigger mode from each source: channel 1, channel 2, link on both codes.
		for (int i = 0; i < 4; i++) begin
			restart(slv_w(tsts_pkg::TSTS_SMS_TRIG, tsel[i], 1'b0, 16'h0));
			check({16'h0, cnt}, 32'h0);
			ch1 <= (i == 0);
			ch2 <= (i == 1);
			gate <= (i > 1);
			wt(2);
			if (i < 2) check({16'h0, cnt}, 32'h0);
			wt(8);
			check(cnt != 16'h0, 1'b1);
			// The update generate write in restart sets the update flag as well.
			rd_chk(tsts_pkg::TSTS_OFS_FLAG, 32'h3);
			bus(1'b0, tsts_pkg::TSTS_OFS_CTRL, 32'h0);
			check(q[0], 1'b1);
			bus(1'b1, tsts_pkg::TSTS_OFS_FLAG, 32'h3);
			rd_chk(tsts_pkg::TSTS_OFS_FLAG, 32'h0);
			bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b0, 1'b0, 3'h0, 16'hFFFF));
			wt(2);
			c1 = cnt;
			wt(5);
			check({16'h0, cnt}, {16'h0, c1});
			ch1 <= 1'b0;
			ch2 <= 1'b0;
			gate <= 1'b0;
		end
		// Master output: compare reference, enable, update pulse.
		ccr = 16'(20 + $urandom_range(200));
		restart(slv_w(3'h0, 3'h0, 1'b0, ccr));
		bus(1'b1, tsts_pkg::TSTS_OFS_CNT, 32'h0000_00E7);
		rd_chk(tsts_pkg::TSTS_OFS_CNT, 32'h0000_00E7);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b0, 1'b0, 3'h4, 16'hFFFF));
		bus(1'b1, tsts_pkg::TSTS_OFS_CNT, {16'h0, ccr - 16'h1});
		wt(3);
		check(trigger_output, 1'b1);
		check(cmp1, 1'b1);
		bus(1'b1, tsts_pkg::TSTS_OFS_CNT, {16'h0, ccr});
		wt(3);
		check(trigger_output, 1'b0);
		check(cmp1, 1'b0);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b1, 1'b0, 3'h1, 16'hFFFF));
		wt(3);
		check(trigger_output, 1'b1);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b0, 1'b0, 3'h1, 16'hFFFF));
		wt(3);
		check(trigger_output, 1'b0);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b0, 1'b1, 3'h2, 16'h0008));
		wt(3);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b1, 1'b0, 3'h2, 16'h0008));
		k = 0;
		while (trigger_output !== 1'b1 && k < 40) begin
			@(posedge clk);
			k++;
		end
		check(k < 40, 1'b1);
		@(posedge clk);
		check(trigger_output, 1'b0);
		// Gated by the link; a stop holds the count and a restart resumes it.
		// The align bit is set here so the delayed prescaler enable is exercised.
		restart(slv_w(tsts_pkg::TSTS_SMS_GATED, tsts_pkg::TSTS_TS_ITR_A, 1'b0, 16'h0) | 32'h80);
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b1, 1'b0, 3'h0, 16'hFFFF));
		wt(10);
		check({16'h0, cnt}, 32'h0);
		gate <= 1'b1;
		wt(10);
		c1 = cnt;
		check(c1 != 16'h0, 1'b1);
		gate <= 1'b0;
		wt(4);
		c2 = cnt;
		wt(10);
		check({16'h0, cnt}, {16'h0, c2});
		gate <= 1'b1;
		wt(10);
		check(cnt > c2 && c2 >= c1, 1'b1);
		gate <= 1'b0;
		// External clock mode 1: each link pulse counts once.
		restart(slv_w(tsts_pkg::TSTS_SMS_EXT1, tsts_pkg::TSTS_TS_ITR_A, 1'b0, 16'h0));
		bus(1'b1, tsts_pkg::TSTS_OFS_CTRL, ctrl_w(1'b1, 1'b0, 3'h0, 16'hFFFF));
		pulses(3, 1'b0);
		wt(4);
		check({16'h0, cnt}, 32'h3);
		// External clock mode 2 with trigger mode on channel 1.
		k = 1 + $urandom_range(4);
		restart(slv_w(tsts_pkg::TSTS_SMS_TRIG, tsts_pkg::TSTS_TS_CH1, 1'b1, 16'h0));
		pulses(2, 1'b1);
		check({16'h0, cnt}, 32'h0);
		ch1 <= 1'b1;
		wt(6);
		rd_chk(tsts_pkg::TSTS_OFS_FLAG, 32'h3);
		pulses(k, 1'b1);
		wt(4);
		check({16'h0, cnt}, 32'(k));
		final_report;
	end
endmodule
